// ---- rtl/sdgc_top.sv ----
// socket detect and global control register pair with resume and irq logic
// assumes a byte register port in the socket space, one read or write a cycle,
// card pins synchronous to ref_clk
//
// Contract
// - bit 7 reads live second sense pin
// - bit 6 reads live first sense pin
// - writing bit 5 raises detect change when enabled
// - bit 5 inert when disabled, reads zero
// - resume enable drives ring/wake low on a detect pin change, not on a software trigger
// - ring/wake stays low until flag cleared
// - detect bits 3,2,0 read zero, ignore writes
// - bit 1 resets socket registers on removal
// - global bits 7 to 5 read zero
// - global bit 4 picks card b irq style
// - global bit 3 picks card a irq style
// - global bit 2 picks flag clear style
// - global bit 1 picks status-change irq style
// - power-down floats outputs outside card cycles
// - interrupts still pass in power-down
`timescale 1ns/1ps
module sdgc_top import sdgc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic voltage_sense_first,
	input wire logic voltage_sense_second,
	input wire logic card_present_first,
	input wire logic card_present_second,
	input wire logic card_a_irq_req,
	input wire logic card_b_irq_req,
	input wire logic card_cycle_active,
	output logic card_out_en,
	output logic ring_wake_output,
	output logic socket_regs_reset,
	output logic irq_card_a,
	output logic irq_card_b,
	output logic irq_status_change
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_b; // first stage, read only by the second
	logic rst_sync_b; // released reset for all other logic

	// two-flop release; assertion is immediate, release is clocked
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_sync_b);

	// ----------------------------------------------------------------
	// card-detect change detection
	// ----------------------------------------------------------------
	logic hw_change; // either detect pin moved
	logic card_removed; // card left the socket

	sdgc_detect_change u_detect (
		.ref_clk(ref_clk),
		.rst_sync_b(rst_sync_b),
		.card_present_first(card_present_first),
		.card_present_second(card_present_second),
		.detect_change(hw_change),
		.card_removed(card_removed)
	);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic detect_resume_enable; // resume on detect change
	logic reset_on_removal; // wipe socket registers on removal
	logic detect_change_irq_enable; // lets software trigger and irq through
	logic change_flag; // card-detect change flag
	logic ring_low; // ring/wake held low
	logic [4:0] glob; // global control writable bits 4..0
	logic next_detect_resume_enable;
	logic next_reset_on_removal;
	logic next_detect_change_irq_enable;
	logic next_change_flag;
	logic next_ring_low;
	logic [4:0] next_glob;

	// decoded accesses
	logic wr_detect; // write to detect/control
	logic wr_glob; // write to global control
	logic wr_sc; // write to status change
	logic wr_cfg; // write to change configuration
	logic rd_sc; // read of status change
	logic sw_trigger; // software detect trigger accepted
	logic flag_clear; // flag clear request this cycle
	logic flag_set; // flag set request this cycle
	logic wipe; // removal wipe of socket registers

	// decode, set/clear and wipe; set always beats clear
	always_comb begin
		wr_detect = reg_wr && (reg_addr == SDGC_OFS_DETECT_CTRL);
		wr_glob = reg_wr && (reg_addr == SDGC_OFS_GLOBAL_CTRL);
		wr_sc = reg_wr && (reg_addr == SDGC_OFS_STATUS_CHANGE);
		wr_cfg = reg_wr && (reg_addr == SDGC_OFS_CHANGE_CFG);
		rd_sc = reg_rd && (reg_addr == SDGC_OFS_STATUS_CHANGE);
		wipe = card_removed && reset_on_removal;
		// trigger only counts while the detect irq is enabled
		sw_trigger = wr_detect && reg_wdata[SDGC_DC_SW_TRIG] && detect_change_irq_enable;
		flag_set = hw_change || sw_trigger;
		// read-clear or write-one-clear by global style
		if (glob[SDGC_GC_CLR_STYLE]) begin
			flag_clear = wr_sc && reg_wdata[SDGC_SC_DETECT];
		end else begin
			flag_clear = rd_sc;
		end

		// detect/control writable bits; reserved bits never stored
		next_detect_resume_enable = detect_resume_enable;
		next_reset_on_removal = reset_on_removal;
		if (wr_detect) begin
			next_detect_resume_enable = reg_wdata[SDGC_DC_RESUME];
			next_reset_on_removal = reg_wdata[SDGC_DC_RST_RM];
		end

		// change configuration enable
		next_detect_change_irq_enable = detect_change_irq_enable;
		if (wr_cfg) begin
			next_detect_change_irq_enable = reg_wdata[SDGC_CF_DETECT_EN];
		end

		// global control keeps only bits 4..0
		next_glob = glob;
		if (wr_glob) begin
			next_glob = reg_wdata[4:0];
		end

		// flag: set wins over clear
		if (flag_set) begin
			next_change_flag = 1'b1;
		end else if (flag_clear) begin
			next_change_flag = 1'b0;
		end else begin
			next_change_flag = change_flag;
		end

		// removal wipe of the socket's own registers, flag kept for the removal
		if (wipe) begin
			next_detect_resume_enable = SDGC_BIT_RST;
			next_detect_change_irq_enable = SDGC_BIT_RST;
		end

		// ring/wake: goes low on a detect pin change with resume enabled, not on a software trigger
		// held low only while the flag stays set
		next_ring_low = next_change_flag && (ring_low || (hw_change && detect_resume_enable));
	end

	// register state, all writable bits reset low
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			detect_resume_enable <= SDGC_BIT_RST;
			reset_on_removal <= SDGC_BIT_RST;
			detect_change_irq_enable <= SDGC_BIT_RST;
			change_flag <= SDGC_BIT_RST;
			ring_low <= SDGC_BIT_RST;
			glob <= 5'h00;
		end else begin
			detect_resume_enable <= next_detect_resume_enable;
			reset_on_removal <= next_reset_on_removal;
			detect_change_irq_enable <= next_detect_change_irq_enable;
			change_flag <= next_change_flag;
			ring_low <= next_ring_low;
			glob <= next_glob;
		end
	end

	// ----------------------------------------------------------------
	// read data and pin outputs
	// ----------------------------------------------------------------
	logic [7:0] next_reg_rdata;
	logic next_card_out_en;
	logic next_ring_wake_output;
	logic next_socket_regs_reset;

	// read mux; sense bits are live pins with no stored value
	always_comb begin
		next_reg_rdata = SDGC_BYTE_ZERO; // unmapped and reserved read zero
		if (reg_rd) begin
			unique case (reg_addr)
				SDGC_OFS_DETECT_CTRL: begin
					next_reg_rdata[SDGC_DC_SENSE2] = voltage_sense_second;
					next_reg_rdata[SDGC_DC_SENSE1] = voltage_sense_first;
					next_reg_rdata[SDGC_DC_RESUME] = detect_resume_enable;
					next_reg_rdata[SDGC_DC_RST_RM] = reset_on_removal;
					// trigger bit and bits 3,2,0 stay zero
				end
				SDGC_OFS_GLOBAL_CTRL: begin
					next_reg_rdata[4:0] = glob; // bits 7..5 stay zero
				end
				SDGC_OFS_STATUS_CHANGE: begin
					next_reg_rdata[SDGC_SC_DETECT] = change_flag;
				end
				SDGC_OFS_CHANGE_CFG: begin
					next_reg_rdata[SDGC_CF_DETECT_EN] = detect_change_irq_enable;
				end
				default: begin
					next_reg_rdata = SDGC_BYTE_ZERO;
				end
			endcase
		end
		// power-down: drive only during an active card cycle
		next_card_out_en = !glob[SDGC_GC_LOW_PWR] || card_cycle_active;
		next_ring_wake_output = !next_ring_low;
		next_socket_regs_reset = wipe;
	end

	// output flops; ring/wake idles high
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= SDGC_BYTE_ZERO;
			card_out_en <= 1'b1;
			ring_wake_output <= 1'b1;
			socket_regs_reset <= SDGC_BIT_RST;
		end else begin
			reg_rdata <= next_reg_rdata;
			card_out_en <= next_card_out_en;
			ring_wake_output <= next_ring_wake_output;
			socket_regs_reset <= next_socket_regs_reset;
		end
	end

	// ----------------------------------------------------------------
	// host interrupt signalling
	// ----------------------------------------------------------------
	logic [SDGC_IRQ_CHANNELS-1:0] irq_req; // per-source request level
	logic [SDGC_IRQ_CHANNELS-1:0] irq_lvl; // per-source level style
	logic [SDGC_IRQ_CHANNELS-1:0] irq_out; // per-source host line

	// requests are not gated by power-down
	always_comb begin
		irq_req[SDGC_CH_A] = card_a_irq_req;
		irq_req[SDGC_CH_B] = card_b_irq_req;
		irq_req[SDGC_CH_SC] = change_flag && detect_change_irq_enable;
		irq_lvl[SDGC_CH_A] = glob[SDGC_GC_A_STYLE];
		irq_lvl[SDGC_CH_B] = glob[SDGC_GC_B_STYLE];
		irq_lvl[SDGC_CH_SC] = glob[SDGC_GC_SC_STYLE];
	end

	// one signalling unit per source
	for (genvar ch = 0; ch < SDGC_IRQ_CHANNELS; ch++) begin : g_irq
		sdgc_irq_style u_style (
			.ref_clk(ref_clk),
			.rst_sync_b(rst_sync_b),
			.req(irq_req[ch]),
			.level_style(irq_lvl[ch]),
			.irq(irq_out[ch])
		);
	end

	// the submodule outputs are flops themselves
	assign irq_card_a = irq_out[SDGC_CH_A];
	assign irq_card_b = irq_out[SDGC_CH_B];
	assign irq_status_change = irq_out[SDGC_CH_SC];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_sense_live: assert property (reg_rd && reg_addr == SDGC_OFS_DETECT_CTRL |=>
		reg_rdata[SDGC_DC_SENSE2] == $past(voltage_sense_second)
		&& reg_rdata[SDGC_DC_SENSE1] == $past(voltage_sense_first))
		else $error("sense bits not live");
	a_detect_rsvd: assert property (reg_rd && reg_addr == SDGC_OFS_DETECT_CTRL |=>
		reg_rdata[SDGC_DC_SW_TRIG] == 1'b0 && reg_rdata[3:2] == 2'h0 && !reg_rdata[0])
		else $error("detect reserved or trigger bit nonzero");
	a_glob_rsvd: assert property (reg_rd && reg_addr == SDGC_OFS_GLOBAL_CTRL |=>
		reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(glob))
		else $error("global control read wrong");
	a_trigger_sets: assert property (wr_detect && reg_wdata[SDGC_DC_SW_TRIG]
		&& detect_change_irq_enable && !change_flag && !wipe |=> change_flag ##1 irq_status_change)
		else $error("software trigger lost");
	a_trigger_inert: assert property (wr_detect && !detect_change_irq_enable
		&& !hw_change && !change_flag |=> !change_flag)
		else $error("trigger acted while disabled");
	a_ring_fall: assert property (hw_change && detect_resume_enable |=>
		!ring_wake_output)
		else $error("ring/wake did not fall");
	a_ring_hold: assert property (!ring_wake_output |-> $past(change_flag)
		|| $past(hw_change))
		else $error("ring/wake low without flag");
	a_read_clear: assert property (rd_sc && !glob[SDGC_GC_CLR_STYLE] && !flag_set
		|=> !change_flag)
		else $error("read did not clear flag");
	a_removal_wipe: assert property (card_removed && reset_on_removal |=>
		!detect_resume_enable && socket_regs_reset)
		else $error("removal wipe missing");
	a_power_down: assert property (glob[SDGC_GC_LOW_PWR] && !card_cycle_active
		|=> !card_out_en)
		else $error("outputs driven in power-down");

endmodule : sdgc_top

// ---- shared/sdgc_pkg.sv ----
// socket detect / global control package: offsets, bit positions, reset values
// assumes byte-wide socket register space with 8-bit offsets
package sdgc_pkg;

	// ----------------------------------------------------------------
	// register offsets in the socket register space
	// ----------------------------------------------------------------
	localparam logic [7:0] SDGC_OFS_STATUS_CHANGE = 8'h04; // status_change_register
	localparam logic [7:0] SDGC_OFS_CHANGE_CFG = 8'h05; // status-change irq configuration
	localparam logic [7:0] SDGC_OFS_DETECT_CTRL = 8'h16; // card_detect_general_control
	localparam logic [7:0] SDGC_OFS_GLOBAL_CTRL = 8'h1e; // socket_global_control

	// ----------------------------------------------------------------
	// card_detect_general_control fields
	// ----------------------------------------------------------------
	localparam int SDGC_DC_SENSE2 = 7; // sense2_level
	localparam int SDGC_DC_SENSE1 = 6; // sense1_level
	localparam int SDGC_DC_SW_TRIG = 5; // software detect trigger, reads zero
	localparam int SDGC_DC_RESUME = 4; // detect_resume_enable
	localparam int SDGC_DC_RST_RM = 1; // reset_on_removal

	// ----------------------------------------------------------------
	// socket_global_control fields
	// ----------------------------------------------------------------
	localparam int SDGC_GC_B_STYLE = 4; // card_b_irq_style
	localparam int SDGC_GC_A_STYLE = 3; // card_a_irq_style
	localparam int SDGC_GC_CLR_STYLE = 2; // flag_clear_style
	localparam int SDGC_GC_SC_STYLE = 1; // status_change_irq_style
	localparam int SDGC_GC_LOW_PWR = 0; // low_power_select

	// ----------------------------------------------------------------
	// status-change register and its configuration
	// ----------------------------------------------------------------
	localparam int SDGC_SC_DETECT = 0; // card-detect change flag
	localparam int SDGC_CF_DETECT_EN = 3; // detect_change_irq_enable

	// ----------------------------------------------------------------
	// reset values and misc
	// ----------------------------------------------------------------
	localparam logic SDGC_BIT_RST = 1'b0; // every writable bit resets low
	localparam logic [7:0] SDGC_BYTE_ZERO = 8'h00; // reserved / unmapped read data
	localparam int SDGC_IRQ_CHANNELS = 3; // card a, card b, status change
	localparam int SDGC_CH_A = 0;
	localparam int SDGC_CH_B = 1;
	localparam int SDGC_CH_SC = 2;
	localparam logic SDGC_STYLE_EDGE = 1'b0; // edge mode select value

endpackage : sdgc_pkg

// ---- rtl/sdgc_detect_change.sv ----
// card-detect change and removal detector for the two detect pins
// assumes the detect pins are synchronous to ref_clk and low while seated
`timescale 1ns/1ps
module sdgc_detect_change import sdgc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_sync_b,
	input wire logic card_present_first,
	input wire logic card_present_second,
	output logic detect_change,
	output logic card_removed
);

	// ----------------------------------------------------------------
	// history of the pins
	// ----------------------------------------------------------------
	logic [1:0] prev_pins; // pins seen last cycle
	logic prev_valid; // history holds a real sample
	logic [1:0] next_prev_pins;
	logic next_prev_valid;
	logic [1:0] now_pins; // current pin pair

	// next history; no change is reported before the first real sample
	always_comb begin
		now_pins = {card_present_second, card_present_first};
		next_prev_pins = now_pins;
		next_prev_valid = 1'b1;
		// change on either pin
		detect_change = prev_valid && (now_pins != prev_pins);
		// seated means both low; removal is seated to not seated
		card_removed = prev_valid && (prev_pins == 2'h0) && (now_pins != 2'h0);
	end

	// history register
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			prev_pins <= 2'h0;
			prev_valid <= SDGC_BIT_RST;
		end else begin
			prev_pins <= next_prev_pins;
			prev_valid <= next_prev_valid;
		end
	end

endmodule : sdgc_detect_change

// ---- rtl/sdgc_irq_style.sv ----
// host interrupt signalling for one source: edge pulse or level follow
// assumes req is a level that stays high while the source wants service
`timescale 1ns/1ps
module sdgc_irq_style import sdgc_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_sync_b,
	input wire logic req,
	input wire logic level_style,
	output logic irq
);

	// ----------------------------------------------------------------
	// edge detect and output register
	// ----------------------------------------------------------------
	logic req_seen; // req value last cycle
	logic next_req_seen;
	logic next_irq;

	// edge mode gives one pulse per rising request, level mode follows it
	always_comb begin
		next_req_seen = req;
		if (level_style != SDGC_STYLE_EDGE) begin
			next_irq = req;
		end else begin
			next_irq = req && !req_seen;
		end
	end

	// registered so the host sees a clean flop output
	always_ff @(posedge ref_clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			req_seen <= SDGC_BIT_RST;
			irq <= SDGC_BIT_RST;
		end else begin
			req_seen <= next_req_seen;
			irq <= next_irq;
		end
	end

	// edge mode never holds the line two cycles
	a_edge_single: assert property (@(posedge ref_clk) disable iff (!rst_sync_b)
		(level_style == SDGC_STYLE_EDGE) && irq |=> !irq || $past(level_style))
		else $error("edge style irq held high");

endmodule : sdgc_irq_style

// ---- sim/sdgc_card_model.sv ----
// card-side stand-in: sense, detect, card interrupt and card cycle pins
// assumes the bench calls set_pins from its own ref_clk sequence
`timescale 1ns/1ps
module sdgc_card_model (
	input wire logic ref_clk,
	output logic voltage_sense_second,
	output logic voltage_sense_first,
	output logic card_present_second,
	output logic card_present_first,
	output logic card_a_irq_req,
	output logic card_b_irq_req,
	output logic card_cycle_active
);
	// ----------------------------------------------------------------
	// pin state
	// ----------------------------------------------------------------
	// card seated (detect pins low), quiet, at time zero
	initial begin
		{voltage_sense_second, voltage_sense_first} = 2'b00;
		{card_present_second, card_present_first} = 2'b00;
		{card_a_irq_req, card_b_irq_req, card_cycle_active} = 3'b000;
	end

	// pins change just after an edge, as a synchronous card would
	task automatic set_pins(input logic [6:0] v);
		@(posedge ref_clk);
		{voltage_sense_second, voltage_sense_first} <= v[6:5];
		{card_present_second, card_present_first} <= v[4:3];
		{card_a_irq_req, card_b_irq_req, card_cycle_active} <= v[2:0];
	endtask : set_pins
endmodule : sdgc_card_model

// ---- sim/socket_detect_global_control_tb_top.sv ----
// self-checking bench for the detect/control and global control registers
// assumes single-clock byte register port, card pins from sdgc_card_model
`timescale 1ns/1ps
module socket_detect_global_control_tb_top import sdgc_pkg::*;;
	// ----------------------------------------------------------------
	// signals and reference model state
	// ----------------------------------------------------------------
	logic ref_clk, rst_b, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
	logic sns1, sns2, cp1, cp2, ia, ib, cyc;
	logic out_en, ring, sreset, irq_a, irq_b, irq_sc;
	logic [6:0] pins; // {sns2, sns1, cp2, cp1, irq a, irq b, cycle}
	int m_dc, m_gc; // writable bits as the host last set them
	int err_count, num_checks, cnt_a, cnt_b, cnt_sc, cnt_rst, c0, c1;

	sdgc_card_model card (.ref_clk(ref_clk), .voltage_sense_second(sns2),
		.voltage_sense_first(sns1), .card_present_second(cp2),
		.card_present_first(cp1), .card_a_irq_req(ia), .card_b_irq_req(ib),
		.card_cycle_active(cyc));

	sdgc_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .voltage_sense_first(sns1),
		.voltage_sense_second(sns2), .card_present_first(cp1),
		.card_present_second(cp2), .card_a_irq_req(ia), .card_b_irq_req(ib),
		.card_cycle_active(cyc), .card_out_en(out_en), .ring_wake_output(ring),
		.socket_regs_reset(sreset), .irq_card_a(irq_a), .irq_card_b(irq_b),
		.irq_status_change(irq_sc));

	// ----------------------------------------------------------------
	// clock and pulse counters
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// edge-style outputs are one-cycle pulses, so count them every edge
	always @(posedge ref_clk) begin
		cnt_a += (irq_a === 1'b1);
		cnt_b += (irq_b === 1'b1);
		cnt_sc += (irq_sc === 1'b1);
		cnt_rst += (sreset === 1'b1);
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// write strobe held for exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		if (a == SDGC_OFS_DETECT_CTRL) m_dc = d & 8'h12;
		if (a == SDGC_OFS_GLOBAL_CTRL) m_gc = d & 8'h1f;
	endtask : wr

	// read data stands only in the cycle after the read edge
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		chk(nm, rv, exp);
	endtask : rdchk

	task automatic put(input logic [6:0] v);
		pins = v;
		card.set_pins(v);
	endtask : put

	// bounded wait for ring/wake; running out ends the run
	task automatic wait_ring(input logic v);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			if (ring === v) return;
		end
		err_count++;
		$display("ERROR ring_wake expected %b seen %b", v, ring);
		wrap_up();
	endtask : wait_ring

	// expected detect/control read: live sense pins over the writable bits
	function automatic logic [7:0] dcx();
		return {pins[6:5], 6'h00} | 8'(m_dc);
	endfunction : dcx

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		{m_dc, m_gc, err_count, num_checks, cnt_a, cnt_b, cnt_sc, cnt_rst} = '0;
		pins = 7'h00;
		void'($urandom(32'h351d493d));
		repeat (20) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdchk(SDGC_OFS_GLOBAL_CTRL, 8'h00, "global_reset");
		rdchk(SDGC_OFS_DETECT_CTRL, dcx(), "detect_reset");
		// random sense levels and random register data, enable still off
		for (int i = 0; i < 8; i++) begin
			put({2'($urandom), 5'h00});
			wr(SDGC_OFS_DETECT_CTRL, 8'($urandom));
			rdchk(SDGC_OFS_DETECT_CTRL, dcx(), "detect_rw");
			wr(SDGC_OFS_GLOBAL_CTRL, 8'($urandom));
			rdchk(SDGC_OFS_GLOBAL_CTRL, 8'(m_gc), "global_rw");
		end
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h00, "trigger_disabled");
		wr(8'h30, 8'hff);
		rdchk(8'h30, 8'h00, "unmapped");
		wr(SDGC_OFS_GLOBAL_CTRL, 8'h00);
		wr(SDGC_OFS_DETECT_CTRL, 8'h00);
		// software trigger, edge irq, clear on read
		wr(SDGC_OFS_CHANGE_CFG, 8'h08);
		c0 = cnt_sc;
		wr(SDGC_OFS_DETECT_CTRL, 8'h20);
		repeat (4) @(posedge ref_clk);
		chk("sc_edge_pulses", 8'(cnt_sc - c0), 8'h01);
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_set");
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h00, "flag_read_clear");
		// level style follows the flag until the read clears it
		wr(SDGC_OFS_GLOBAL_CTRL, 8'h02);
		wr(SDGC_OFS_DETECT_CTRL, 8'h20);
		repeat (4) @(posedge ref_clk);
		chk("sc_level", {7'h00, irq_sc}, 8'h01);
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_level");
		repeat (3) @(posedge ref_clk);
		chk("sc_level_drop", {7'h00, irq_sc}, 8'h00);
		// write-one clear style
		wr(SDGC_OFS_GLOBAL_CTRL, 8'h04);
		wr(SDGC_OFS_DETECT_CTRL, 8'h20);
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_w1c_set");
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_kept");
		wr(SDGC_OFS_STATUS_CHANGE, 8'h01);
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h00, "flag_w1c");
		// resume on removal and reinsertion, no wipe
		wr(SDGC_OFS_GLOBAL_CTRL, 8'h00);
		wr(SDGC_OFS_DETECT_CTRL, 8'h10);
		c1 = cnt_rst;
		for (int k = 0; k < 2; k++) begin
			put(pins ^ 7'h08);
			wait_ring(1'b0);
			repeat (6) @(posedge ref_clk);
			chk("ring_held", {7'h00, ring}, 8'h00);
			rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_by_pin");
			wait_ring(1'b1);
		end
		chk("no_wipe", 8'(cnt_rst - c1), 8'h00);
		// resume off: a pin change leaves ring/wake high
		wr(SDGC_OFS_DETECT_CTRL, 8'h00);
		put(pins ^ 7'h08);
		repeat (6) @(posedge ref_clk);
		chk("ring_idle", {7'h00, ring}, 8'h01);
		put(pins ^ 7'h08);
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_no_resume");
		// removal wipe: resume cleared, reset_on_removal kept
		wr(SDGC_OFS_DETECT_CTRL, 8'h12);
		c1 = cnt_rst;
		put(pins | 7'h18);
		wait_ring(1'b0);
		repeat (4) @(posedge ref_clk);
		chk("wipe_pulse", 8'(cnt_rst - c1), 8'h01);
		m_dc = 8'h02;
		rdchk(SDGC_OFS_DETECT_CTRL, dcx(), "wipe_result");
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_removal");
		wait_ring(1'b1);
		put(pins & 7'h67);
		rdchk(SDGC_OFS_STATUS_CHANGE, 8'h01, "flag_insert");
		wr(SDGC_OFS_DETECT_CTRL, 8'h00);
		// card a / card b styles, all four combinations
		for (int m = 0; m < 4; m++) begin
			wr(SDGC_OFS_GLOBAL_CTRL, 8'(m << 3));
			c0 = cnt_a;
			c1 = cnt_b;
			put(pins | 7'h06);
			repeat (5) @(posedge ref_clk);
			chk("card_irq_level", {6'h00, irq_b, irq_a}, 8'(m));
			if (m[0] == 1'b0) chk("card_a_edge", 8'(cnt_a - c0), 8'h01);
			if (m[1] == 1'b0) chk("card_b_edge", 8'(cnt_b - c1), 8'h01);
			put(pins & 7'h79);
			repeat (3) @(posedge ref_clk);
		end
		// power-down: outputs float outside card cycles, irqs still pass
		wr(SDGC_OFS_GLOBAL_CTRL, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk("pd_float", {7'h00, out_en}, 8'h00);
		put(pins | 7'h01);
		repeat (3) @(posedge ref_clk);
		chk("pd_cycle", {7'h00, out_en}, 8'h01);
		put(pins & 7'h7e);
		repeat (3) @(posedge ref_clk);
		chk("pd_refloat", {7'h00, out_en}, 8'h00);
		c0 = cnt_a;
		put(pins | 7'h04);
		repeat (4) @(posedge ref_clk);
		chk("pd_irq", 8'(cnt_a - c0), 8'h01);
		put(pins & 7'h7b);
		wr(SDGC_OFS_GLOBAL_CTRL, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk("pd_off", {7'h00, out_en}, 8'h01);
		wrap_up();
	end

	// overall limit against a stalled sequence
	initial begin
		#200000;
		err_count++;
		$display("ERROR watchdog expected finish seen hang");
		wrap_up();
	end
endmodule : socket_detect_global_control_tb_top
